/* File: igv_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the capture gain and volume registers
// Assumes: Register indices are word indices, byte address is four times the index
// Notes:   Definitions only
`ifndef IGV_MAP_SVH
`define IGV_MAP_SVH

// ==========================================================================
// Register indices
`define IGV_IDX_CAP0_VOL    8'h1f
`define IGV_IDX_CAP1_VOL    8'h20
`define IGV_IDX_CAP2_VOL    8'h21
`define IGV_IDX_CAP3_VOL    8'h22
`define IGV_IDX_AMP0_CTL    8'h23
`define IGV_IDX_AMP1_CTL    8'h24
`define IGV_IDX_AMP2_CTL    8'h25
`define IGV_IDX_LEVELS      8'h30

// ==========================================================================
// Field positions
`define IGV_AMP_MIC_BIT     7
`define IGV_AMP_MUTE_BIT    6
`define IGV_AMP_GAIN_MSB    5

// ==========================================================================
// Reset values
`define IGV_VOL_RESET       8'h00
`define IGV_AMP_RESET       8'h40
`define IGV_VOL_FULL_ATTEN  8'hff

// ==========================================================================
// Timing and bus answers
`define IGV_RAMP_TICKS      5'h10
`define IGV_RESP_OKAY       2'h0
`define IGV_RESP_SLVERR     2'h2

`endif

/* File: igv_pkg.sv */
// Purpose: Types shared by the capture gain and volume register bank
// Assumes: Nothing beyond the map header
// Notes:   Types only
package igv_pkg;
    typedef logic [7:0] igv_byte_t;
    typedef enum logic {igv_wr_idle, igv_wr_resp} igv_wr_state_t;
endpackage

/* File: igv_ramp_if.sv */
// Purpose: Carrier between the register bank and one volume ramp
// Assumes: One instance per capture channel
// Notes:   Level comes from a flip-flop in the ramp
`timescale 1ns/100ps
`default_nettype none
interface igv_ramp_if;
    logic       enable;
    logic [7:0] target;
    logic [7:0] level;
    modport ctrl (output enable, output target, input level);
    modport ramp (input enable, input target, output level);
endinterface
`default_nettype wire

/* File: igv_ramp.sv */
// Purpose: Digital volume ramp of one capture channel
// Assumes: sample_tick is a one-cycle pulse once per sample period
// Notes:   Level code is attenuation, 0.375 dB per code
`timescale 1ns/100ps
`default_nettype none
`include "igv_map.svh"
module igv_ramp
    import igv_pkg::*;
(
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire logic   ce,
    input  wire logic   sample_tick,
    igv_ramp_if.ramp    rp
);
    logic       en_d_ff;
    logic [3:0] div_ff;
    igv_byte_t  level_ff;
    logic [3:0] nxt_div;
    igv_byte_t  nxt_level;
    logic       step_due;

    // ==========================================================================
    // Step timing
    // A fresh enable restarts the divider so the first step is a full period late
    assign step_due  = sample_tick && (div_ff == 4'(`IGV_RAMP_TICKS - 5'h01));
    assign nxt_div   = (!rp.enable || !en_d_ff) ? 4'h0 :
                       sample_tick ? div_ff + 4'h1 : div_ff;
    // Moves one code toward the target, either way, then holds
    assign nxt_level = (!rp.enable || !en_d_ff) ? `IGV_VOL_FULL_ATTEN :
                       !step_due || (level_ff == rp.target) ? level_ff :
                       (level_ff > rp.target) ? level_ff - 8'h01 :
                       level_ff + 8'h01;
    assign rp.level  = level_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            en_d_ff  <= 1'b0;
            div_ff   <= 4'h0;
            level_ff <= `IGV_VOL_FULL_ATTEN;
        end
        else if (ce)
        begin
            en_d_ff  <= rp.enable;
            div_ff   <= nxt_div;
            level_ff <= nxt_level;
        end
    end
endmodule
`default_nettype wire

/* File: igv_regs.sv */
// Purpose: Capture volume and input amplifier control registers on an AXI4-Lite slave
// Assumes: Inputs synchronous to aclk; sample_tick pulses once per sample period
// Notes:   Unmapped addresses answer SLVERR, reads of them return zero
//
// Operation
// - Decimator enable starts volume at full attenuation
// - Each volume step lasts sixteen sample periods
// - Ramp counts over 256 attenuation steps
// - Volume code linear, 0.375 dB per code
// - Four volume registers read/write, reset zero
// - Bit 7 selects microphone, powers amplifier
// - Bit 6 mutes, gain ignored, resets muted
// - Six-bit gain, -12 dB plus 0.75 dB/code
// - Amplifier registers reset to 0x40
// - Amplifier register N drives analog input N
`timescale 1ns/100ps
`default_nettype none
`include "igv_map.svh"
module igv_regs
    import igv_pkg::*;
(
    input  wire logic           aclk,
    input  wire logic           aresetn,
    input  wire logic           ce,
    input  wire logic           sample_tick,
    input  wire logic           decimator0_enable,
    input  wire logic           decimator1_enable,
    input  wire logic           decimator2_enable,
    input  wire logic           decimator3_enable,
    input  wire logic [9:0]     s_axi_awaddr,
    input  wire logic           s_axi_awvalid,
    output logic                s_axi_awready,
    input  wire logic [31:0]    s_axi_wdata,
    input  wire logic [3:0]     s_axi_wstrb,
    input  wire logic           s_axi_wvalid,
    output logic                s_axi_wready,
    output logic [1:0]          s_axi_bresp,
    output logic                s_axi_bvalid,
    input  wire logic           s_axi_bready,
    input  wire logic [9:0]     s_axi_araddr,
    input  wire logic           s_axi_arvalid,
    output logic                s_axi_arready,
    output logic [31:0]         s_axi_rdata,
    output logic [1:0]          s_axi_rresp,
    output logic                s_axi_rvalid,
    input  wire logic           s_axi_rready,
    output logic [7:0]          capture0_level,
    output logic [7:0]          capture1_level,
    output logic [7:0]          capture2_level,
    output logic [7:0]          capture3_level,
    output logic [2:0]          amp_mic_select,
    output logic [2:0]          amp_silence,
    output logic [5:0]          amp0_gain_code,
    output logic [5:0]          amp1_gain_code,
    output logic [5:0]          amp2_gain_code
);
    localparam igv_byte_t VOL_IDX [4] = '{`IGV_IDX_CAP0_VOL, `IGV_IDX_CAP1_VOL,
                                          `IGV_IDX_CAP2_VOL, `IGV_IDX_CAP3_VOL};
    localparam igv_byte_t AMP_IDX [3] = '{`IGV_IDX_AMP0_CTL, `IGV_IDX_AMP1_CTL, `IGV_IDX_AMP2_CTL};

    igv_wr_state_t  wr_state_ff;
    logic           aw_hold_ff;
    logic           w_hold_ff;
    logic [9:0]     waddr_ff;
    logic [7:0]     wdata_ff;
    logic           wstrb0_ff;
    logic [1:0]     bresp_ff;
    logic           rvalid_ff;
    logic [31:0]    rdata_ff;
    logic [1:0]     rresp_ff;
    igv_byte_t      vol_ff [4];
    igv_byte_t      amp_ff [3];
    logic [5:0]     gain_out_ff [3];
    igv_byte_t      level_w [4];
    logic [3:0]     dec_en_w;
    logic [3:0]     wr_vol_hit;
    logic [2:0]     wr_amp_hit;
    logic [3:0]     rd_vol_hit;
    logic [2:0]     rd_amp_hit;
    logic           do_write;
    logic           wr_mapped;
    logic           rd_mapped;
    logic           rd_levels_hit;
    logic [7:0]     wr_idx;
    logic [7:0]     rd_idx;
    logic [31:0]    rd_mux;
    logic           ar_take;

    // ==========================================================================
    // Write channel decode
    // Address and data are caught independently, so either may arrive first
    // Readies drop with ce, so a master never sees an address or data transfer that the frozen bank ignores; a response taken while ce is low stays valid
    assign s_axi_awready = ce && !aw_hold_ff && (wr_state_ff == igv_wr_idle);
    assign s_axi_wready  = ce && !w_hold_ff && (wr_state_ff == igv_wr_idle);
    assign s_axi_bvalid  = (wr_state_ff == igv_wr_resp);
    assign s_axi_bresp   = bresp_ff;
    assign do_write      = aw_hold_ff && w_hold_ff && (wr_state_ff == igv_wr_idle);
    assign wr_idx        = waddr_ff[9:2];
    assign wr_mapped     = |wr_vol_hit || |wr_amp_hit || (wr_idx == `IGV_IDX_LEVELS);

    // ==========================================================================
    // Read channel decode
    assign s_axi_arready = ce && !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign ar_take       = s_axi_arvalid && !rvalid_ff;
    assign rd_idx        = s_axi_araddr[9:2];
    assign rd_levels_hit = (rd_idx == `IGV_IDX_LEVELS);
    assign rd_mapped     = |rd_vol_hit || |rd_amp_hit || rd_levels_hit;
    assign rd_mux        = rd_vol_hit[0] ? {24'h000000, vol_ff[0]} :
                           rd_vol_hit[1] ? {24'h000000, vol_ff[1]} :
                           rd_vol_hit[2] ? {24'h000000, vol_ff[2]} :
                           rd_vol_hit[3] ? {24'h000000, vol_ff[3]} :
                           rd_amp_hit[0] ? {24'h000000, amp_ff[0]} :
                           rd_amp_hit[1] ? {24'h000000, amp_ff[1]} :
                           rd_amp_hit[2] ? {24'h000000, amp_ff[2]} :
                           rd_levels_hit ? {level_w[3], level_w[2], level_w[1], level_w[0]} :
                           32'h00000000;

    assign dec_en_w = {decimator3_enable, decimator2_enable, decimator1_enable, decimator0_enable};

    // ==========================================================================
    // Capture channels
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_cap
            igv_ramp_if rif ();
            assign rif.enable     = dec_en_w[gi];
            assign rif.target     = vol_ff[gi];
            assign level_w[gi]    = rif.level;
            assign wr_vol_hit[gi] = (wr_idx == VOL_IDX[gi]);
            assign rd_vol_hit[gi] = (rd_idx == VOL_IDX[gi]);

            igv_ramp u_ramp (
                .aclk        (aclk),
                .aresetn     (aresetn),
                .ce          (ce),
                .sample_tick (sample_tick),
                .rp          (rif.ramp)
            );

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    vol_ff[gi] <= `IGV_VOL_RESET;
                else if (ce && do_write && wstrb0_ff && wr_vol_hit[gi])
                    vol_ff[gi] <= wdata_ff;
            end
        end
    endgenerate

    // ==========================================================================
    // Input amplifier controls
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_amp
            assign wr_amp_hit[gi]     = (wr_idx == AMP_IDX[gi]);
            assign rd_amp_hit[gi]     = (rd_idx == AMP_IDX[gi]);
            // Line mode keeps the amplifier powered down
            assign amp_mic_select[gi] = amp_ff[gi][`IGV_AMP_MIC_BIT];
            assign amp_silence[gi]    = amp_ff[gi][`IGV_AMP_MUTE_BIT];

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    amp_ff[gi]      <= `IGV_AMP_RESET;
                    gain_out_ff[gi] <= 6'h00;
                end
                else if (ce)
                begin
                    if (do_write && wstrb0_ff && wr_amp_hit[gi])
                        amp_ff[gi] <= wdata_ff;
                    // Gain code held frozen while muted, so unmuting resumes cleanly
                    if (!amp_ff[gi][`IGV_AMP_MUTE_BIT])
                        gain_out_ff[gi] <= amp_ff[gi][`IGV_AMP_GAIN_MSB:0];
                end
            end
        end
    endgenerate

    assign amp0_gain_code = gain_out_ff[0];
    assign amp1_gain_code = gain_out_ff[1];
    assign amp2_gain_code = gain_out_ff[2];
    assign capture0_level = level_w[0];
    assign capture1_level = level_w[1];
    assign capture2_level = level_w[2];
    assign capture3_level = level_w[3];

    // ==========================================================================
    // Write handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_ff <= igv_wr_idle;
            aw_hold_ff  <= 1'b0;
            w_hold_ff   <= 1'b0;
            waddr_ff    <= 10'h000;
            wdata_ff    <= 8'h00;
            wstrb0_ff   <= 1'b0;
            bresp_ff    <= `IGV_RESP_OKAY;
        end
        else if (ce)
        begin
            case (wr_state_ff)
                igv_wr_idle:
                begin
                    if (s_axi_awvalid && s_axi_awready)
                    begin
                        aw_hold_ff <= 1'b1;
                        waddr_ff   <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && s_axi_wready)
                    begin
                        w_hold_ff <= 1'b1;
                        wdata_ff  <= s_axi_wdata[7:0];
                        wstrb0_ff <= s_axi_wstrb[0];
                    end
                    if (do_write)
                    begin
                        aw_hold_ff  <= 1'b0;
                        w_hold_ff   <= 1'b0;
                        bresp_ff    <= wr_mapped ? `IGV_RESP_OKAY : `IGV_RESP_SLVERR;
                        wr_state_ff <= igv_wr_resp;
                    end
                end
                igv_wr_resp:
                begin
                    if (s_axi_bready)
                        wr_state_ff <= igv_wr_idle;
                end
                default:
                    wr_state_ff <= igv_wr_idle;
            endcase
        end
    end

    // ==========================================================================
    // Read handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= `IGV_RESP_OKAY;
        end
        else if (ce)
        begin
            if (ar_take)
            begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rd_mux;
                rresp_ff  <= rd_mapped ? `IGV_RESP_OKAY : `IGV_RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: igv_regs_props.sv */
// Purpose: Concurrent checks on the capture volume and amplifier register bank
// Assumes: One clock aclk, synchronous active-low aresetn
// Notes:   Channel 0 and amplifier 0 stand for their siblings
`timescale 1ns/100ps
`default_nettype none
module igv_regs_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic        sample_tick,
    input wire logic        decimator0_enable,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [7:0]  capture0_level,
    input wire logic [2:0]  amp_silence,
    input wire logic [5:0]  amp0_gain_code
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================================
    // Ramp divider model, wraps like a 4-bit divider so holds need no reload
    logic [3:0] ticks_ff;
    logic [3:0] nxt_ticks;
    logic       en_seen_ff;
    // The first enabled cycle only arms the count, as in the ramp
    assign nxt_ticks = (decimator0_enable && en_seen_ff) ? ticks_ff + {3'h0, sample_tick} : 4'h0;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ticks_ff   <= 4'h0;
            en_seen_ff <= 1'b0;
        end
        else if (ce)
        begin
            ticks_ff   <= nxt_ticks;
            en_seen_ff <= decimator0_enable;
        end
    end
    sequence en_held;
        decimator0_enable ##1 decimator0_enable;
    endsequence
    // ==========================================================================
    // Properties
    chk_idle_full_atten: assert property (ce && !decimator0_enable |=> capture0_level == 8'hff)
        else $error("level not full attenuation while disabled");
    chk_level_one_step: assert property (en_held ##0 $changed(capture0_level)
        |-> capture0_level == $past(capture0_level) + 8'h01 || capture0_level == $past(capture0_level) - 8'h01)
        else $error("level moved by more than one code");
    chk_step_sixteen: assert property (en_held ##0 $changed(capture0_level)
        |-> $past(sample_tick) && ticks_ff == 4'h0)
        else $error("level step not on sixteenth sample tick");
    chk_gain_frozen: assert property (amp_silence[0] ##1 amp_silence[0] |-> $stable(amp0_gain_code))
        else $error("gain moved while muted");
    chk_reset_state: assert property ($rose(aresetn)
        |-> amp_silence == 3'b111 && capture0_level == 8'hff && amp0_gain_code == 6'h00)
        else $error("outputs not at reset state");
    chk_bresp_stands: assert property (s_axi_bvalid && !(s_axi_bready && ce)
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_stands: assert property (s_axi_rvalid && !(s_axi_rready && ce)
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while one pending");
endmodule
bind igv_regs igv_regs_props igv_regs_props_inst (.*);
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the capture volume and amplifier register bank
// Assumes: 20 MHz aclk, bus driven just after rising edges, answers sampled at the falling edge
// Notes:   Volumes 0 to 2 sit near full attenuation so their ramps stay short; volume 3 is written zero
`timescale 1ns/100ps
`default_nettype none
`include "igv_map.svh"
module testbench;
    logic        aclk, aresetn, ce, sample_tick;
    logic        decimator0_enable, decimator1_enable, decimator2_enable, decimator3_enable;
    logic [9:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [7:0]  capture0_level, capture1_level, capture2_level, capture3_level;
    logic [2:0]  amp_mic_select, amp_silence;
    logic [5:0]  amp0_gain_code, amp1_gain_code, amp2_gain_code;
    logic [73:0] rows [0:8];
    int          failures, n_checks;
    igv_regs igv_regs_inst (.*);
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // ==========================================================================
    // Tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic give_up();
        failures++;
        $display("ERROR handshake expected answer seen none");
        give_verdict();
    endtask
    // Ready is raised late on purpose so the slave must hold its answer
    task automatic wr(input logic [7:0] idx, input logic [31:0] data, output logic [1:0] resp);
        logic a, w, b;
        int   k;
        @(posedge aclk);
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_wdata   <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        for (k = 0; k < 40; k++)
        begin
            @(negedge aclk);
            a = s_axi_awready && s_axi_awvalid;
            w = s_axi_wready && s_axi_wvalid;
            b = s_axi_bvalid && s_axi_bready;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) break;
            if (k == 2) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        if (k == 40) give_up();
    endtask
    task automatic rd(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
        logic a, v;
        int   k;
        @(posedge aclk);
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        for (k = 0; k < 40; k++)
        begin
            @(negedge aclk);
            a = s_axi_arready && s_axi_arvalid;
            v = s_axi_rvalid && s_axi_rready;
            data = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (a) s_axi_arvalid <= 1'b0;
            if (v) break;
            if (k == 1) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        if (k == 40) give_up();
    endtask
    task automatic tk(input int n);
        repeat (n)
        begin
            @(posedge aclk);
            sample_tick <= 1'b1;
            @(posedge aclk);
            sample_tick <= 1'b0;
            repeat (2) @(posedge aclk);
        end
        @(negedge aclk);
    endtask
    function automatic logic [31:0] lv();
        return {capture3_level, capture2_level, capture1_level, capture0_level};
    endfunction
    // ==========================================================================
    // Main sequence
    initial
    begin
        failures = 0;
        n_checks = 0;
        {aresetn, sample_tick, ce, s_axi_wstrb} = 7'h1f;
        {decimator3_enable, decimator2_enable, decimator1_enable, decimator0_enable} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
        rows[0] = {`IGV_IDX_CAP0_VOL, 32'h0000_00fd, 32'h0000_00fd, `IGV_RESP_OKAY};
        rows[1] = {`IGV_IDX_CAP1_VOL, 32'h0000_00fe, 32'h0000_00fe, `IGV_RESP_OKAY};
        rows[2] = {`IGV_IDX_CAP2_VOL, 32'h0000_00ff, 32'h0000_00ff, `IGV_RESP_OKAY};
        rows[3] = {`IGV_IDX_CAP3_VOL, 32'habcd_ef00, 32'h0000_0000, `IGV_RESP_OKAY};
        rows[4] = {`IGV_IDX_AMP0_CTL, 32'h1234_5690, 32'h0000_0090, `IGV_RESP_OKAY};
        rows[5] = {`IGV_IDX_AMP1_CTL, 32'h0000_003f, 32'h0000_003f, `IGV_RESP_OKAY};
        rows[6] = {`IGV_IDX_AMP2_CTL, 32'h0000_00c5, 32'h0000_00c5, `IGV_RESP_OKAY};
        rows[7] = {8'h26, 32'h0000_0011, 32'h0000_0000, `IGV_RESP_SLVERR};
        rows[8] = {`IGV_IDX_LEVELS, 32'h0000_0000, 32'hffff_ffff, `IGV_RESP_OKAY};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            rd(rows[i][73:66], d, r);
            chk("reset value", (rows[i][73:66] inside {[`IGV_IDX_AMP0_CTL:`IGV_IDX_AMP2_CTL]}) ?
                {24'h0, `IGV_AMP_RESET} : {24'h0, `IGV_VOL_RESET}, d);
            chk("reset resp", {30'h0, rows[i][1:0]}, {30'h0, r});
        end
        @(negedge aclk);
        chk("reset levels", 32'hffff_ffff, lv());
        chk("reset amp", 32'h7, {26'h0, amp_mic_select, amp_silence});
        $display("test reset done");
        for (int i = 0; i < 9; i++)
        begin
            wr(rows[i][73:66], rows[i][65:34], r);
            chk("write resp", {30'h0, rows[i][1:0]}, {30'h0, r});
            rd(rows[i][73:66], d, r);
            chk("read data", rows[i][33:2], d);
            chk("read resp", {30'h0, rows[i][1:0]}, {30'h0, r});
        end
        // Amp2 stayed muted since reset, so its gain code must not follow
        @(negedge aclk);
        chk("amp select mute", 32'h2c, {26'h0, amp_mic_select, amp_silence});
        chk("amp gains", {14'h0, 6'h00, 6'h3f, 6'h10},
            {14'h0, amp2_gain_code, amp1_gain_code, amp0_gain_code});
        $display("test table done");
        // Muting amp0 must freeze its gain code at the last unmuted value
        wr(`IGV_IDX_AMP0_CTL, 32'h0000_007f, r);
        @(negedge aclk);
        chk("muted gain", 32'h0000_0010, {26'h0, amp0_gain_code});
        @(posedge aclk);
        s_axi_wstrb <= 4'he;
        wr(`IGV_IDX_CAP1_VOL, 32'h0000_0011, r);
        s_axi_wstrb <= 4'hf;
        rd(`IGV_IDX_CAP1_VOL, d, r);
        chk("masked write", 32'h0000_00fe, d);
        $display("test awkward writes done");
        {decimator3_enable, decimator2_enable, decimator1_enable, decimator0_enable} <= 4'hf;
        repeat (2) @(posedge aclk);
        tk(15);
        chk("ramp start", 32'hffff_ffff, lv());
        tk(1);
        chk("ramp first", 32'hfeff_fefe, lv());
        rd(`IGV_IDX_LEVELS, d, r);
        chk("levels reg", 32'hfeff_fefe, d);
        tk(32);
        chk("ramp target", 32'hfcff_fefd, lv());
        tk(16);
        chk("ramp hold", 32'hfbff_fefd, lv());
        // A target above the level makes the ramp climb back one code
        wr(`IGV_IDX_CAP0_VOL, 32'h0000_00fe, r);
        tk(16);
        chk("ramp up", 32'hfaff_fefe, lv());
        @(posedge aclk);
        ce <= 1'b0;
        tk(16);
        chk("ce freeze", 32'hfaff_fefe, lv());
        @(posedge aclk);
        ce <= 1'b1;
        decimator0_enable <= 1'b0;
        repeat (2) @(negedge aclk);
        chk("disabled", 32'hfaff_feff, lv());
        $display("test ramp done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("rereset levels", 32'hffff_ffff, lv());
        rd(`IGV_IDX_AMP1_CTL, d, r);
        chk("rereset amp", 32'h40, d);
        $display("test second reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
